// ===== verilog/compare_pwm_unit.sv
// Compare and PWM unit: 16-bit compare against the wide timer, 10-bit PWM
// ==========================================================
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module compare_pwm_unit (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Wide timer and converter
  input wire logic [15:0] i_wide_timer_count,
  input wire logic i_wide_timer_tick,
  input wire logic i_adc_enable,
  output logic o_wide_timer_clear,
  output logic o_special_trigger,
  output logic o_adc_start,
  output logic o_match_flag,
  // Pin and power
  input wire logic i_pin_direction_bit,
  input wire logic i_sleep,
  output logic o_unit_pin_out,
  output logic o_unit_pin_oe
);

  // ==========================================================
  // Helpers

  // Low two timebase bits picked by the prescale setting
  function automatic logic [1:0] low_bits(input logic [1:0] ps, input logic [1:0] q, input logic [3:0] pre);
    if (ps == cpwm_pkg::PS_DIV1) begin
      low_bits = q;
    end else if (ps == cpwm_pkg::PS_DIV4) begin
      low_bits = pre[1:0];
    end else begin
      low_bits = pre[3:2];
    end
  endfunction : low_bits

  // Compare sub-modes in which a match means something
  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == cpwm_pkg::MODE_TOGGLE) || (m == cpwm_pkg::MODE_SET) || (m == cpwm_pkg::MODE_CLEAR)
      || (m == cpwm_pkg::MODE_SWINT) || (m == cpwm_pkg::MODE_TRIGGER);
  endfunction : is_compare

  cpwm_pkg::st_s st;
  cpwm_pkg::st_s next_st;

  logic [3:0] mode;
  logic pwm_mode;
  logic match;
  logic match_rise;
  logic tb_on;
  logic inc;
  logic [1:0] ps;
  logic [9:0] tb10;
  logic [9:0] duty_active;
  logic [9:0] duty_buffered;

  // Decode of the current configuration
  always_comb begin
    mode = st.unit_control[cpwm_pkg::MODE_MSB:0];
    pwm_mode = (mode[3:2] == cpwm_pkg::MODE_PWM_TOP);
    tb_on = st.timebase_control[cpwm_pkg::TB_ON_BIT];
    ps = st.timebase_control[1:0];
    match = is_compare(mode) && ({st.cmp_high, st.cmp_low} == i_wide_timer_count);
    match_rise = match && !st.match_prev;
    tb10 = {st.pwm_timebase_count, low_bits(ps, st.quarter, st.pre)};
    duty_active = {st.cmp_high, st.duty_low_latch};
    duty_buffered = {st.cmp_low, st.unit_control[cpwm_pkg::DUTY_LOW_MSB:cpwm_pkg::DUTY_LOW_LSB]};
    // One timebase step per four oscillator periods times prescale
    if (ps == cpwm_pkg::PS_DIV1) begin
      inc = tb_on && (st.quarter == cpwm_pkg::QUARTER_LAST);
    end else if (ps == cpwm_pkg::PS_DIV4) begin
      inc = tb_on && (st.quarter == cpwm_pkg::QUARTER_LAST) && (st.pre[1:0] == cpwm_pkg::PRE4_LAST);
    end else begin
      inc = tb_on && (st.quarter == cpwm_pkg::QUARTER_LAST) && (st.pre == cpwm_pkg::PRE16_LAST);
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.special_trigger = 1'b0;
    next_st.wide_timer_clear = 1'b0;
    next_st.adc_start = 1'b0;

    // Sleep freezes counters, latches and the pin level, not the pin enable; register reads and writes still work then
    if (!i_sleep) begin
      // Timebase counters
      if (tb_on) begin
        next_st.quarter = st.quarter + 2'h1;
        if (st.quarter == cpwm_pkg::QUARTER_LAST) begin
          next_st.pre = st.pre + 4'h1;
        end
      end
      // PWM waveform; period end wins over a duty match in the same cycle
      if (inc && (st.pwm_timebase_count == st.period_limit)) begin
        next_st.pwm_timebase_count = 8'h00;
        next_st.quarter = 2'h0;
        next_st.pre = 4'h0;
        next_st.pwm_latch = (duty_buffered != 10'h000);
        if (pwm_mode) begin
          next_st.cmp_high = st.cmp_low;
          next_st.duty_low_latch = duty_buffered[1:0];
        end
      end else begin
        if (inc) begin
          next_st.pwm_timebase_count = st.pwm_timebase_count + 8'h01;
        end
        // Look at the value the timebase steps to, so the pin is low in the very cycle it equals the duty
        // Duty larger than period simply never matches here
        if ({next_st.pwm_timebase_count, low_bits(ps, next_st.quarter, next_st.pre)} == duty_active) begin
          next_st.pwm_latch = 1'b0;
        end
      end

      // Compare side acts once per match
      next_st.match_prev = match;
      if (match_rise) begin
        case (mode)
          cpwm_pkg::MODE_TOGGLE: begin
            next_st.cmp_latch = !st.cmp_latch;
          end
          cpwm_pkg::MODE_SET: begin
            next_st.cmp_latch = 1'b1;
          end
          cpwm_pkg::MODE_CLEAR: begin
            next_st.cmp_latch = 1'b0;
          end
          cpwm_pkg::MODE_TRIGGER: begin
            next_st.special_trigger = 1'b1;
            next_st.adc_start = i_adc_enable;
          end
          default: begin
            next_st.cmp_latch = st.cmp_latch;
          end
        endcase
      end

      // Timer clear waits for the timer edge and only if the match still holds
      case (st.trg)
        cpwm_pkg::TRG_IDLE: begin
          if (match_rise && (mode == cpwm_pkg::MODE_TRIGGER)) begin
            next_st.trg = cpwm_pkg::TRG_WAIT;
          end
        end
        cpwm_pkg::TRG_WAIT: begin
          if (!match) begin
            next_st.trg = cpwm_pkg::TRG_IDLE;
          end else if (i_wide_timer_tick) begin
            next_st.wide_timer_clear = 1'b1;
            next_st.trg = cpwm_pkg::TRG_IDLE;
          end
        end
        default: begin
          next_st.trg = cpwm_pkg::TRG_IDLE;
        end
      endcase
    end

    // Register writes
    if (i_wr) begin
      if (i_addr == cpwm_pkg::ADDR_UNIT_CONTROL) begin
        next_st.unit_control = i_wdata[5:0];
        if (i_wdata[5:0] == 6'h00) begin
          next_st.cmp_latch = 1'b0;
          next_st.pwm_latch = 1'b0;
          next_st.trg = cpwm_pkg::TRG_IDLE;
        end
      end else if (i_addr == cpwm_pkg::ADDR_CMP_LOW) begin
        next_st.cmp_low = i_wdata;
      end else if (i_addr == cpwm_pkg::ADDR_CMP_HIGH) begin
        if (!pwm_mode) begin
          next_st.cmp_high = i_wdata;
        end
      end else if (i_addr == cpwm_pkg::ADDR_PERIOD_LIMIT) begin
        next_st.period_limit = i_wdata;
      end else if (i_addr == cpwm_pkg::ADDR_TIMEBASE_CONTROL) begin
        next_st.timebase_control = i_wdata[2:0];
      end else if (i_addr == cpwm_pkg::ADDR_PWM_TIMEBASE) begin
        next_st.pwm_timebase_count = i_wdata;
      end
    end

    // Flag: write one to clear, a match in the same cycle wins
    if (i_wr && (i_addr == cpwm_pkg::ADDR_STATUS) && i_wdata[cpwm_pkg::STATUS_FLAG_BIT]) begin
      next_st.match_flag = 1'b0;
    end
    if (!i_sleep && match_rise) begin
      next_st.match_flag = 1'b1;
    end

    // Pin: compare modes drive only set, clear and toggle; direction bit gates
    if (pwm_mode) begin
      next_st.pin_out = next_st.pwm_latch;
      next_st.pin_oe = !i_pin_direction_bit;
    end else begin
      next_st.pin_out = next_st.cmp_latch;
      next_st.pin_oe = !i_pin_direction_bit && ((mode == cpwm_pkg::MODE_TOGGLE) || (mode == cpwm_pkg::MODE_SET)
        || (mode == cpwm_pkg::MODE_CLEAR));
    end
    if (i_sleep) begin
      next_st.pin_out = st.pin_out;
    end

    // Read data stands the cycle after the strobe only
    next_st.rdata = 8'h00;
    if (i_rd) begin
      if (i_addr == cpwm_pkg::ADDR_UNIT_CONTROL) begin
        next_st.rdata = {2'h0, st.unit_control};
      end else if (i_addr == cpwm_pkg::ADDR_CMP_LOW) begin
        next_st.rdata = st.cmp_low;
      end else if (i_addr == cpwm_pkg::ADDR_CMP_HIGH) begin
        next_st.rdata = st.cmp_high;
      end else if (i_addr == cpwm_pkg::ADDR_PERIOD_LIMIT) begin
        next_st.rdata = st.period_limit;
      end else if (i_addr == cpwm_pkg::ADDR_TIMEBASE_CONTROL) begin
        next_st.rdata = {5'h00, st.timebase_control};
      end else if (i_addr == cpwm_pkg::ADDR_STATUS) begin
        next_st.rdata = {5'h00, st.trg == cpwm_pkg::TRG_WAIT, st.pin_out, st.match_flag};
      end else if (i_addr == cpwm_pkg::ADDR_PWM_TIMEBASE) begin
        next_st.rdata = st.pwm_timebase_count;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.unit_control <= cpwm_pkg::UNIT_CONTROL_RST;
      st.period_limit <= cpwm_pkg::PERIOD_LIMIT_RST;
      st.timebase_control <= cpwm_pkg::TIMEBASE_CONTROL_RST;
      st.trg <= cpwm_pkg::TRG_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign o_rdata = st.rdata;
  assign o_wide_timer_clear = st.wide_timer_clear;
  assign o_special_trigger = st.special_trigger;
  assign o_adc_start = st.adc_start;
  assign o_match_flag = st.match_flag;
  assign o_unit_pin_out = st.pin_out;
  assign o_unit_pin_oe = st.pin_oe;

  // ==========================================================
  // Checks

  a_flag_on_match: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && match_rise) |=> o_match_flag) else $error("match did not set flag");

  a_action_once: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_special_trigger |=> !o_special_trigger) else $error("trigger repeated while matched");

  a_trigger_at_match: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && match_rise && mode == cpwm_pkg::MODE_TRIGGER) |=> o_special_trigger)
    else $error("trigger not issued at match");

  a_adc_needs_enable: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_adc_start |-> (o_special_trigger && $past(i_adc_enable))) else $error("adc start without enable");

  a_clear_needs_match: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_wide_timer_clear |-> ($past(match) && $past(i_wide_timer_tick) && $past(st.trg) == cpwm_pkg::TRG_WAIT))
    else $error("timer cleared without standing match");

  a_swint_pin_free: assert property (@(posedge i_mclk) disable iff (i_rst)
    (mode == cpwm_pkg::MODE_SWINT || mode == cpwm_pkg::MODE_TRIGGER) |=> !o_unit_pin_oe)
    else $error("pin driven in flag-only mode");

  a_zero_ctrl_low: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_wr && i_addr == cpwm_pkg::ADDR_UNIT_CONTROL && i_wdata == 8'h00 && !i_sleep) |=> !o_unit_pin_out)
    else $error("zero control did not force latch low");

  a_direction_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_pin_direction_bit |=> !o_unit_pin_oe) else $error("pin driven with direction bit set");

  a_period_wrap: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && inc && st.pwm_timebase_count == st.period_limit && !(i_wr && i_addr == cpwm_pkg::ADDR_PWM_TIMEBASE))
    |=> (st.pwm_timebase_count == 8'h00)) else $error("timebase did not wrap at limit");

  a_sleep_freeze: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_sleep && !i_wr) |=> ($stable(st.pwm_timebase_count) && $stable(o_unit_pin_out) && $stable(o_match_flag)))
    else $error("state moved during sleep");

  // Compare actions on the output latch and the wide timer clear
  a_set_latch_high: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && match_rise && mode == cpwm_pkg::MODE_SET && !(i_wr && i_addr == cpwm_pkg::ADDR_UNIT_CONTROL))
    |=> st.cmp_latch) else $error("set mode match left latch low");

  a_clear_latch_low: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && match_rise && mode == cpwm_pkg::MODE_CLEAR && !(i_wr && i_addr == cpwm_pkg::ADDR_UNIT_CONTROL))
    |=> !st.cmp_latch) else $error("clear mode match left latch high");

  a_toggle_latch_flips: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && match_rise && mode == cpwm_pkg::MODE_TOGGLE && !(i_wr && i_addr == cpwm_pkg::ADDR_UNIT_CONTROL))
    |=> (st.cmp_latch != $past(st.cmp_latch))) else $error("toggle mode match did not flip latch");

  a_swint_latch_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && match_rise && mode == cpwm_pkg::MODE_SWINT && !(i_wr && i_addr == cpwm_pkg::ADDR_UNIT_CONTROL))
    |=> $stable(st.cmp_latch)) else $error("flag-only match moved the latch");

  a_clear_single_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_wide_timer_clear |=> !o_wide_timer_clear) else $error("timer clear longer than one cycle");

  a_clear_after_tick: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && st.trg == cpwm_pkg::TRG_WAIT && match && i_wide_timer_tick)
    |=> o_wide_timer_clear) else $error("timer edge with standing match gave no clear");

  // PWM waveform and duty buffering
  a_zero_duty_low: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && inc && st.pwm_timebase_count == st.period_limit && duty_buffered == 10'h000)
    |=> !st.pwm_latch) else $error("zero duty raised the pin");

  a_duty_latched: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && pwm_mode && inc && st.pwm_timebase_count == st.period_limit)
    |=> (st.cmp_high == $past(st.cmp_low) && st.duty_low_latch == $past(duty_buffered[1:0])))
    else $error("duty not latched at period end");

  a_active_read_only: assert property (@(posedge i_mclk) disable iff (i_rst)
    (pwm_mode && !(inc && st.pwm_timebase_count == st.period_limit))
    |=> ($stable(st.cmp_high) && $stable(st.duty_low_latch))) else $error("active duty moved mid period");

  a_low_at_duty: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_sleep && !i_wr && pwm_mode) |=> (tb10 != duty_active || !st.pwm_latch))
    else $error("pin high with timebase at duty");

  a_quarter_steps: assert property (@(posedge i_mclk) disable iff (i_rst)
    (tb_on && !i_sleep) |=> (st.quarter == 2'($past(st.quarter) + 2'h1))) else $error("quarter counter skipped");

  a_duty_beyond_period: assert property (@(posedge i_mclk) disable iff (i_rst)
    (pwm_mode && !i_wr && st.pwm_latch && st.pwm_timebase_count <= st.period_limit
    && duty_active > {st.period_limit, 2'h3} && !(inc && st.pwm_timebase_count == st.period_limit))
    |=> st.pwm_latch) else $error("duty beyond period cleared the pin");

  a_pin_follows_pwm: assert property (@(posedge i_mclk) disable iff (i_rst)
    (pwm_mode && !i_sleep) |=> (o_unit_pin_out == st.pwm_latch)) else $error("pin left the waveform latch");

endmodule : compare_pwm_unit
`default_nettype wire

// ===== verilog/cpwm_pkg.sv
// Constants, register map and state types for the compare and PWM unit
package cpwm_pkg;

  // ==========================================================
  // Register map (word index on the plain register port)
  localparam logic [2:0] ADDR_UNIT_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_CMP_LOW = 3'h1;
  localparam logic [2:0] ADDR_CMP_HIGH = 3'h2;
  localparam logic [2:0] ADDR_PERIOD_LIMIT = 3'h3;
  localparam logic [2:0] ADDR_TIMEBASE_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  localparam logic [2:0] ADDR_PWM_TIMEBASE = 3'h6;

  // ==========================================================
  // Field positions
  localparam int DUTY_LOW_MSB = 5;
  localparam int DUTY_LOW_LSB = 4;
  localparam int MODE_MSB = 3;
  localparam int TB_ON_BIT = 2;
  localparam int STATUS_FLAG_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [5:0] UNIT_CONTROL_RST = 6'h00;
  localparam logic [7:0] PERIOD_LIMIT_RST = 8'hFF;
  localparam logic [2:0] TIMEBASE_CONTROL_RST = 3'h0;

  // ==========================================================
  // Mode select codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SWINT = 4'hA;
  localparam logic [3:0] MODE_TRIGGER = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // Timebase prescale select
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;

  // Oscillator periods per timebase step before prescale
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [1:0] PRE4_LAST = 2'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;

  // Special trigger sequencer
  typedef enum logic [0:0] {
    TRG_IDLE = 1'b0,
    TRG_WAIT = 1'b1
  } trg_e;

  // Whole unit state
  typedef struct packed {
    logic [5:0] unit_control;
    logic [7:0] cmp_low;
    logic [7:0] cmp_high;
    logic [7:0] period_limit;
    logic [2:0] timebase_control;
    logic [7:0] pwm_timebase_count;
    logic [1:0] quarter;
    logic [3:0] pre;
    logic [1:0] duty_low_latch;
    logic cmp_latch;
    logic pwm_latch;
    logic match_prev;
    logic match_flag;
    trg_e trg;
    logic special_trigger;
    logic wide_timer_clear;
    logic adc_start;
    logic pin_out;
    logic pin_oe;
    logic [7:0] rdata;
  } st_s;

endpackage : cpwm_pkg

// ===== testbench/pin_load_model.sv
// Load circuit on the unit pin: resolves the wire level and counts high cycles
`timescale 1ns/1ps
`default_nettype none

module pin_load_model (
  // Clock and pin
  input wire logic i_mclk,
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  // Measurement
  input wire logic i_clr,
  output logic o_level,
  output logic [7:0] o_high_count
);
  // ==========================================================
  // Pull-down holds the pin low whenever the unit lets go of it
  assign o_level = i_pin_oe ? i_pin_out : 1'b0;

  // High-cycle counter; saturates so a stuck pin cannot wrap back to a match
  always_ff @(posedge i_mclk) begin
    if (i_clr) begin
      o_high_count <= 8'h00;
    end else if (o_level && o_high_count != 8'hFF) begin
      o_high_count <= o_high_count + 8'h01;
    end
  end
endmodule : pin_load_model
`default_nettype wire

// ===== testbench/compare_pwm_unit_tb.sv
// Self-checking testbench for the compare and PWM unit
`timescale 1ns/1ps
`default_nettype none

module compare_pwm_unit_tb;
  logic mclk, rst, wr_s, rd_s, tick, adc_en, dir, sleep, clr, o_clr, o_trg, o_adc, o_flag, o_pin, o_oe, lvl;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, hc, v, w;
  logic [15:0] cnt;
  int err_count = 0;
  int checked = 0;

  compare_pwm_unit compare_pwm_unit_i (.i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_wide_timer_count(cnt), .i_wide_timer_tick(tick), .i_adc_enable(adc_en),
    .o_wide_timer_clear(o_clr), .o_special_trigger(o_trg), .o_adc_start(o_adc), .o_match_flag(o_flag),
    .i_pin_direction_bit(dir), .i_sleep(sleep), .o_unit_pin_out(o_pin), .o_unit_pin_oe(o_oe));
  pin_load_model pin_load_model_i (.i_mclk(mclk), .i_pin_out(o_pin), .i_pin_oe(o_oe), .i_clr(clr),
    .o_level(lvl), .o_high_count(hc));

  // ==========================================================
  // Clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus cycles: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Break the match for one cycle, then present v; returns in the answer cycle
  task automatic match_pulse(input logic [15:0] v16);
    @(posedge mclk);
    cnt <= 16'h0000;
    @(posedge mclk);
    cnt <= v16;
    @(posedge mclk);
    #1;
  endtask : match_pulse

  // Timer clock edge as a one-cycle tick; timer stays synchronous
  task automatic tick_pulse;
    @(posedge mclk);
    tick <= 1'b1;
    @(posedge mclk);
    tick <= 1'b0;
    #1;
  endtask : tick_pulse

  task automatic t_reset_values;
    rd(cpwm_pkg::ADDR_PERIOD_LIMIT, v);
    chk("period limit", 16'h00FF, v);
    rd(cpwm_pkg::ADDR_UNIT_CONTROL, v);
    chk("unit control", 16'h0000, v);
    rd(3'h7, v);
    chk("unmapped", 16'h0000, v);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_compare_pin;
    wr(cpwm_pkg::ADDR_CMP_LOW, 8'h34);
    wr(cpwm_pkg::ADDR_CMP_HIGH, 8'h12);
    wr(cpwm_pkg::ADDR_UNIT_CONTROL, {4'h0, cpwm_pkg::MODE_SET});
    match_pulse(16'h1234);
    chk("set pin", 16'h1, lvl);
    chk("match flag", 16'h1, o_flag);
    wr(cpwm_pkg::ADDR_STATUS, 8'h01);
    repeat (4) @(posedge mclk);
    #1 chk("flag held match", 16'h0, o_flag);
    wr(cpwm_pkg::ADDR_UNIT_CONTROL, {4'h0, cpwm_pkg::MODE_CLEAR});
    match_pulse(16'h1234);
    chk("clear pin", 16'h0, o_pin);
    wr(cpwm_pkg::ADDR_UNIT_CONTROL, {4'h0, cpwm_pkg::MODE_TOGGLE});
    match_pulse(16'h1234);
    chk("toggle up", 16'h1, o_pin);
    match_pulse(16'h1234);
    chk("toggle down", 16'h0, o_pin);
    match_pulse(16'h1234);
    wr(cpwm_pkg::ADDR_UNIT_CONTROL, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk("latch off", 16'h0, o_pin);
    $display("test compare_pin done");
  endtask : t_compare_pin

  task automatic t_compare_events;
    wr(cpwm_pkg::ADDR_UNIT_CONTROL, {4'h0, cpwm_pkg::MODE_SWINT});
    wr(cpwm_pkg::ADDR_STATUS, 8'h01);
    match_pulse(16'h1234);
    chk("swint flag", 16'h1, o_flag);
    chk("swint pin free", 16'h0, o_oe);
    wr(cpwm_pkg::ADDR_UNIT_CONTROL, {4'h0, cpwm_pkg::MODE_TRIGGER});
    adc_en <= 1'b1;
    match_pulse(16'h1234);
    chk("trigger", 16'h1, o_trg);
    chk("adc start", 16'h1, o_adc);
    chk("trigger pin free", 16'h0, o_oe);
    chk("clear waits", 16'h0, o_clr);
    tick_pulse;
    chk("timer clear", 16'h1, o_clr);
    adc_en <= 1'b0;
    match_pulse(16'h1234);
    chk("adc off", 16'h0, o_adc);
    wr(cpwm_pkg::ADDR_CMP_LOW, 8'h35);
    tick_pulse;
    chk("clear skipped", 16'h0, o_clr);
    $display("test compare_events done");
  endtask : t_compare_events

  // PWM: set duty and timebase, settle, then count high cycles over n cycles
  task automatic pwm_run(input logic [7:0] ctl, input logic [7:0] dh, input logic [7:0] tbc, input int n,
                         input logic [7:0] exp);
    wr(cpwm_pkg::ADDR_CMP_LOW, dh);
    wr(cpwm_pkg::ADDR_UNIT_CONTROL, ctl);
    wr(cpwm_pkg::ADDR_TIMEBASE_CONTROL, tbc);
    repeat (150) @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (n) @(posedge mclk);
    #1 chk("high cycles", {8'h00, exp}, {8'h00, hc});
  endtask : pwm_run

  task automatic t_pwm;
    cnt <= 16'h0000;
    wr(cpwm_pkg::ADDR_PERIOD_LIMIT, 8'h00);
    pwm_run(8'h2C, 8'h00, 8'h04, 40, 8'd20);
    chk("pwm driver", 16'h1, o_oe);
    pwm_run(8'h0C, 8'h00, 8'h04, 40, 8'd0);
    pwm_run(8'h2C, 8'h01, 8'h04, 40, 8'd40);
    rd(cpwm_pkg::ADDR_CMP_HIGH, v);
    chk("active duty", 16'h0001, v);
    wr(cpwm_pkg::ADDR_CMP_HIGH, 8'hAA);
    rd(cpwm_pkg::ADDR_CMP_HIGH, v);
    chk("active read only", 16'h0001, v);
    pwm_run(8'h2C, 8'h00, 8'h05, 64, 8'd32);
    pwm_run(8'h2C, 8'h00, 8'h06, 128, 8'd64);
    wr(cpwm_pkg::ADDR_PERIOD_LIMIT, 8'h03);
    pwm_run(8'h2C, 8'h02, 8'h04, 64, 8'd40);
    dir <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("driver off", 16'h0, o_oe);
    dir <= 1'b0;
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_sleep;
    logic hold;
    // Limit above the running count so a wrap comes soon; duty beyond period keeps the pin high
    wr(cpwm_pkg::ADDR_PERIOD_LIMIT, 8'h10);
    pwm_run(8'h2C, 8'hFF, 8'h04, 20, 8'd20);
    sleep <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 hold = lvl;
    rd(cpwm_pkg::ADDR_PWM_TIMEBASE, v);
    repeat (60) @(posedge mclk);
    #1 chk("sleep pin", {15'h0, hold}, lvl);
    rd(cpwm_pkg::ADDR_PWM_TIMEBASE, w);
    chk("sleep count", {8'h00, v}, w);
    sleep <= 1'b0;
    $display("test sleep done");
  endtask : t_sleep

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog: the whole run needs under two thousand cycles
  initial begin
    #500000;
    err_count++;
    tally_and_finish;
  end

  // Main sequence; pin direction cleared for compare and PWM
  initial begin
    {rst, wr_s, rd_s, tick, adc_en, sleep, clr} = 7'b1000000;
    dir = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    cnt = 16'h0000;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset_values;
    t_compare_pin;
    t_compare_events;
    t_pwm;
    t_sleep;
    tally_and_finish;
  end
endmodule : compare_pwm_unit_tb
`default_nettype wire
